/* File: bench/raster_image_palette_decoder_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rip_consts.svh"
module raster_image_palette_decoder_test;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        ready_ff = 1'b0;
   logic [1:0]  lat = 2'h0;
   logic [31:0] reg_rdata, rd;
   logic        irq, src_req, src_ack, pix_valid, pix_set, pix_last;
   logic [15:0] src_addr;
   logic [7:0]  src_data, pix_index, pix_red, pix_green, pix_blue;
   logic [33:0] got_q[$];
   logic [33:0] exp_q[$];
   logic [4:0]  regs [7];
   int          num_errors = 0;
   int          cmp_count = 0;
   localparam logic [7:0] mono_body = 8'hb3;  // Body byte of the mono image.

   always #4 clock = ~clock;

   rip_decoder dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .src_req(src_req),
      .src_addr(src_addr), .src_ack(src_ack), .src_data(src_data), .pix_valid(pix_valid),
      .pix_ready(ready_ff), .pix_set(pix_set), .pix_index(pix_index), .pix_red(pix_red),
      .pix_green(pix_green), .pix_blue(pix_blue), .pix_last(pix_last));

   rip_source_model src (.clock(clock), .rst(rst), .lat(lat), .src_req(src_req),
      .src_addr(src_addr), .src_ack(src_ack), .src_data(src_data));

   // ------------------------------------------------------------------
   // Consumer: stalls every other cycle and records accepted points.
   // ------------------------------------------------------------------
   always @(posedge clock) begin
      ready_ff <= ~ready_ff;
      if (pix_valid === 1'b1 && ready_ff === 1'b1) begin
         got_q.push_back({pix_last, pix_set, pix_index, pix_red, pix_green, pix_blue});
      end
   end

   // ------------------------------------------------------------------
   // Access and comparison tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rdr(input logic [4:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      rdr(a);
      chk({2'b00, rd}, {2'b00, exp});
   endtask

   task automatic load(input logic [7:0] a, input logic [47:0] v);
      for (int i = 0; i < 6; i++) begin
         src.mem[a + 8'(i)] = v[47 - 8 * i -: 8];
      end
   endtask

   // Expected colour point: the palette sits at offset 0x40 for all images.
   task automatic pe(input logic last, input logic [7:0] idx);
      logic [7:0] a;
      a = 8'h40 + idx * 8'h03;
      exp_q.push_back({last, 1'b0, idx, src.mem[a], src.mem[a + 8'h01], src.mem[a + 8'h02]});
   endtask

   // Start one image and wait, bounded, for the done flag.
   task automatic run(input logic [15:0] off, input logic [31:0] ctrl);
      int k;
      got_q.delete();
      wr(`RIP_REG_IMG_OFF, {16'h0000, off});
      wr(`RIP_REG_CTRL, ctrl);
      for (k = 0; k < 300; k++) begin
         rdr(`RIP_REG_STATUS);
         if (rd[1] === 1'b1) break;
      end
      if (k == 300) begin
         num_errors++;
         report_and_stop();
      end
   endtask

   task automatic chk_pts();
      chk(34'(got_q.size()), 34'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < got_q.size()) chk(got_q[i], exp_q[i]);
      end
      exp_q.delete();
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      regs = '{`RIP_REG_CTRL, `RIP_REG_IMG_OFF, `RIP_REG_STATUS, `RIP_REG_GEOM,
               `RIP_REG_IRQ_STAT, `RIP_REG_IRQ_EN, 5'h1e};
      for (int i = 0; i < 256; i++) begin
         src.mem[i] = 8'hff;
      end
      for (int i = 0; i < 24; i++) begin
         src.mem[8'h40 + i] = 8'h10 + 8'(i);
      end
      load(8'h10, 48'h0302b3ffffff);
      load(8'h20, 48'h030103000040);
      load(8'h26, 48'habffffffffff);
      load(8'h30, 48'h020108040040);
      load(8'h36, 48'h0304ffffffff);
      load(8'h55, 48'hff0000ffffff);
      load(8'h60, 48'h010109020040);
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      // Reset values, the unmapped place included, and read data back to zero.
      foreach (regs[i]) rchk(regs[i], 32'h0);
      @(posedge clock);
      #1 chk({2'b00, reg_rdata}, 34'h0);
      // Monochrome 3x2 from a slow source, two padding bits at the end.
      lat <= 2'h3;
      run(16'h0010, 32'h1);
      for (int i = 0; i < 6; i++) begin
         exp_q.push_back({i == 5, mono_body[7 - i], 7'h00, mono_body[7 - i], 24'h0});
      end
      chk_pts();
      rchk(`RIP_REG_POINTS, 32'h6);
      rchk(`RIP_REG_IRQ_STAT, 32'h1);
      chk({33'h0, irq}, 34'h0);
      wr(`RIP_REG_IRQ_EN, 32'h1);
      #1 chk({33'h0, irq}, 34'h1);
      wr(`RIP_REG_IRQ_CLR, 32'h1);
      #1 chk({33'h0, irq}, 34'h0);
      wr(`RIP_REG_IRQ_EN, 32'h3);
      // Colour, three bits a point across a byte edge, 256 entries.
      lat <= 2'h0;
      run(16'h0020, 32'h3);
      pe(1'b0, 8'h05);
      pe(1'b0, 8'h02);
      pe(1'b1, 8'h07);
      chk_pts();
      rchk(`RIP_REG_GEOM, 32'h00030103);
      // Second image on the same palette; its second index is out of range.
      wr(`RIP_REG_IRQ_CLR, 32'h3);
      run(16'h0030, 32'h3);
      pe(1'b0, 8'h03);
      chk_pts();
      rchk(`RIP_REG_STATUS, 32'h6);
      rchk(`RIP_REG_IRQ_STAT, 32'h3);
      chk({33'h0, irq}, 34'h1);
      // Nine bits a point is refused with no points.
      wr(`RIP_REG_IRQ_CLR, 32'h3);
      run(16'h0060, 32'h3);
      chk_pts();
      rchk(`RIP_REG_STATUS, 32'h6);
      report_and_stop();
   end
endmodule // raster_image_palette_decoder_test
`default_nettype wire

/* File: bench/rip_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Image file byte source
// ------------------------------------------------------------------
module rip_source_model (
   input  wire logic        clock,     // Bench clock.
   input  wire logic        rst,       // Synchronous reset, high.
   input  wire logic [1:0]  lat,       // Idle cycles before an answer.
   input  wire logic        src_req,   // Fetch request.
   input  wire logic [15:0] src_addr,  // Byte offset in the file.
   output logic             src_ack,   // One-cycle answer.
   output logic      [7:0]  src_data   // Byte, meaningful with the answer only.
);
   logic [7:0] mem [0:255];  // File contents, loaded by the bench.
   logic [1:0] wait_ff;      // Cycles the current request has waited.

   // Answer after lat waiting cycles. Outside the answer the data lines
   // invert every cycle, so a sample one cycle late sees the inverse of the byte.
   always_ff @(posedge clock) begin
      if (rst) begin
         src_ack <= 1'b0;
         wait_ff <= 2'h0;
         src_data <= 8'h00;
      end else if (src_ack) begin
         src_ack <= 1'b0;
         src_data <= ~src_data;
      end else if (src_req && wait_ff == lat) begin
         src_ack <= 1'b1;
         wait_ff <= 2'h0;
         src_data <= mem[src_addr[7:0]];
      end else begin
         wait_ff <= src_req ? wait_ff + 2'h1 : 2'h0;
         src_data <= ~src_data;
      end
   end
endmodule // rip_source_model
`default_nettype wire

/* File: rtl/rip_consts.svh */
`ifndef RIP_CONSTS_SVH
`define RIP_CONSTS_SVH
// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define RIP_REG_CTRL      5'h00
`define RIP_REG_IMG_OFF   5'h04
`define RIP_REG_STATUS    5'h08
`define RIP_REG_GEOM      5'h0c
`define RIP_REG_IRQ_STAT  5'h10
`define RIP_REG_IRQ_CLR   5'h14
`define RIP_REG_IRQ_EN    5'h18
`define RIP_REG_POINTS    5'h1c
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define RIP_CTRL_START    0
`define RIP_CTRL_COLOUR   1
`define RIP_IRQ_DONE      0
`define RIP_IRQ_ERR       1
// ------------------------------------------------------------------
// Image format figures
// ------------------------------------------------------------------
`define RIP_HDR_LAST_MONO 3'h1
`define RIP_HDR_LAST_COL  3'h5
`define RIP_BODY_MONO     16'h0002
`define RIP_BODY_COL      16'h0006
`define RIP_BPP_MIN       8'h01
`define RIP_BPP_MAX       8'h08
`define RIP_PAL_ZERO_CNT  9'h100
`define RIP_PAL_ENT_BYTES 16'h0003
`define RIP_INT_NONE      8'h00
`endif

/* File: rtl/rip_decoder.sv */
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rip_consts.svh"
module rip_decoder
   import rip_pkg::*;
(
   input  wire logic        clock,      // 125 MHz clock.
   input  wire logic        rst,        // Synchronous reset, high.
   input  wire logic [4:0]  reg_addr,   // Register byte address.
   input  wire logic [31:0] reg_wdata,  // Register write data.
   input  wire logic        reg_wr,     // Register write strobe.
   input  wire logic        reg_rd,     // Register read strobe.
   output logic      [31:0] reg_rdata,  // Read data, cycle after strobe.
   output logic             irq,        // Level interrupt.
   output logic             src_req,    // Byte fetch request.
   output logic      [15:0] src_addr,   // Byte offset in the file.
   input  wire logic        src_ack,    // Fetch answered this cycle.
   input  wire logic [7:0]  src_data,   // Fetched byte.
   output logic             pix_valid,  // Point available.
   input  wire logic        pix_ready,  // Consumer takes the point.
   output logic             pix_set,    // Mono point set.
   output logic      [7:0]  pix_index,  // Palette index of the point.
   output logic      [7:0]  pix_red,    // Red intensity.
   output logic      [7:0]  pix_green,  // Green intensity.
   output logic      [7:0]  pix_blue,   // Blue intensity.
   output logic             pix_last    // Final point of the image.
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   rip_state_t  st_ff;
   logic [31:0] rdata_ff;
   logic [15:0] addr_ff, body_ff, img_off_ff, pal_off_ff, pts_ff, total;
   logic [8:0]  ents_ff;
   logic [7:0]  cur_ff, idx_ff, width_ff, height_ff, bpp_ff, nxt_idx;
   logic [7:0]  pix_idx_ff, pix_r_ff, pix_g_ff, pix_b_ff;
   logic [3:0]  bit_cnt_ff, left_ff;
   logic [2:0]  hdr_ix_ff;
   logic [1:0]  pal_ix_ff, irq_stat_ff, irq_en_ff;
   logic        colour_ff, mode_ff, done_ff, err_ff, pix_last_ff;
   logic        ev_done, ev_err, start, last_bit, bad_bpp;
   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   // The next index shifts in the top bit of the current body byte.
   assign nxt_idx  = {idx_ff[6:0], cur_ff[7]};
   assign total    = {8'h00, width_ff} * {8'h00, height_ff};
   assign last_bit = (({4'h0, bit_cnt_ff} + 8'h01) == bpp_ff);
   assign bad_bpp  = (bpp_ff < `RIP_BPP_MIN) || (bpp_ff > `RIP_BPP_MAX);
   assign start    = reg_wr && (reg_addr == `RIP_REG_CTRL) &&
                     reg_wdata[`RIP_CTRL_START];
   assign src_req  = (st_ff == RIP_HDR) || (st_ff == RIP_BODY) ||
                     (st_ff == RIP_PAL);
   assign src_addr = addr_ff;
   assign pix_valid = (st_ff == RIP_EMIT);
   assign ev_done  = (st_ff == RIP_DONE);
   assign ev_err   = (st_ff == RIP_DONE) && err_ff;
   // ---------------------------------------------------------------
   // Decode sequencer
   // ---------------------------------------------------------------
   // One process owns the walk through header, body and palette so
   // that the fetch address and its purpose can never disagree.
   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff      <= RIP_IDLE;
         hdr_ix_ff  <= 3'h0;
         pal_ix_ff  <= 2'h0;
         bit_cnt_ff <= 4'h0;
         left_ff    <= 4'h0;
         cur_ff     <= 8'h00;
         idx_ff     <= 8'h00;
         addr_ff    <= 16'h0000;
         body_ff    <= 16'h0000;
         pal_off_ff <= 16'h0000;
         pts_ff     <= 16'h0000;
         width_ff   <= 8'h00;
         height_ff  <= 8'h00;
         bpp_ff     <= 8'h00;
         ents_ff    <= 9'h000;
         colour_ff  <= 1'b0;
         done_ff    <= 1'b0;
         err_ff     <= 1'b0;
      end else begin
         case (st_ff)
            RIP_IDLE: begin
               if (start) begin
                  st_ff     <= RIP_HDR;
                  colour_ff <= reg_wdata[`RIP_CTRL_COLOUR];  // Scheme of this very write.
                  hdr_ix_ff <= 3'h0;
                  addr_ff   <= img_off_ff;
                  pts_ff    <= 16'h0000;
                  left_ff   <= 4'h0;
                  done_ff   <= 1'b0;
                  err_ff    <= 1'b0;
                  bpp_ff    <= `RIP_BPP_MIN;
               end
            end
            RIP_HDR: begin
               if (src_ack) begin
                  case (hdr_ix_ff)
                     3'h0: width_ff <= src_data;
                     3'h1: height_ff <= src_data;
                     3'h2: bpp_ff <= src_data;
                     3'h3: ents_ff <= (src_data == 8'h00) ? `RIP_PAL_ZERO_CNT :
                                      {1'b0, src_data};
                     3'h4: pal_off_ff[15:8] <= src_data;
                     default: pal_off_ff[7:0] <= src_data;
                  endcase
                  if (hdr_ix_ff == (colour_ff ? `RIP_HDR_LAST_COL :
                                    `RIP_HDR_LAST_MONO)) begin
                     st_ff <= RIP_CHECK;
                  end else begin
                     hdr_ix_ff <= hdr_ix_ff + 3'h1;
                     addr_ff   <= addr_ff + 16'h0001;
                  end
               end
            end
            RIP_CHECK: begin
               // Body starts right after the header of either scheme.
               body_ff <= img_off_ff + (colour_ff ? `RIP_BODY_COL :
                                        `RIP_BODY_MONO);
               bit_cnt_ff <= 4'h0;
               idx_ff     <= 8'h00;
               if (colour_ff && bad_bpp) begin
                  err_ff <= 1'b1;
                  st_ff  <= RIP_DONE;
               end else if (total == 16'h0000) begin
                  st_ff <= RIP_DONE;
               end else begin
                  st_ff <= RIP_BIT;
               end
            end
            RIP_BIT: begin
               if (left_ff == 4'h0) begin
                  st_ff   <= RIP_BODY;
                  addr_ff <= body_ff;
               end else begin
                  idx_ff     <= nxt_idx;
                  cur_ff     <= {cur_ff[6:0], 1'b1};
                  left_ff    <= left_ff - 4'h1;
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (last_bit) begin
                     bit_cnt_ff <= 4'h0;
                     if (!colour_ff) begin
                        st_ff <= RIP_EMIT;
                     end else if ({1'b0, nxt_idx} >= ents_ff) begin
                        err_ff <= 1'b1;
                        st_ff  <= RIP_DONE;
                     end else begin
                        // Palette base comes from this image only.
                        st_ff     <= RIP_PAL;
                        pal_ix_ff <= 2'h0;
                        addr_ff   <= pal_off_ff +
                                     {8'h00, nxt_idx} * `RIP_PAL_ENT_BYTES;
                     end
                  end
               end
            end
            RIP_BODY: begin
               if (src_ack) begin
                  cur_ff  <= src_data;
                  left_ff <= 4'h8;
                  body_ff <= body_ff + 16'h0001;
                  st_ff   <= RIP_BIT;
               end
            end
            RIP_PAL: begin
               if (src_ack) begin
                  addr_ff   <= addr_ff + 16'h0001;
                  pal_ix_ff <= pal_ix_ff + 2'h1;
                  if (pal_ix_ff == 2'h2) begin
                     st_ff <= RIP_EMIT;
                  end
               end
            end
            RIP_EMIT: begin
               if (pix_ready) begin
                  idx_ff <= 8'h00;
                  pts_ff <= pts_ff + 16'h0001;
                  // Leftover bits of the last byte are dropped here.
                  st_ff  <= pix_last_ff ? RIP_DONE : RIP_BIT;
               end
            end
            RIP_DONE: begin
               done_ff <= 1'b1;
               st_ff   <= RIP_IDLE;
            end
            default: st_ff <= RIP_IDLE;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Point output
   // ---------------------------------------------------------------
   // Intensities pass through unscaled; FF is full and 00 is off.
   always_ff @(posedge clock) begin
      if (rst) begin
         pix_idx_ff  <= 8'h00;
         pix_r_ff    <= `RIP_INT_NONE;
         pix_g_ff    <= `RIP_INT_NONE;
         pix_b_ff    <= `RIP_INT_NONE;
         pix_last_ff <= 1'b0;
      end else begin
         if ((st_ff == RIP_BIT) && (left_ff != 4'h0) && last_bit) begin
            pix_idx_ff  <= nxt_idx;
            pix_last_ff <= ((pts_ff + 16'h0001) == total);
            pix_r_ff    <= `RIP_INT_NONE;
            pix_g_ff    <= `RIP_INT_NONE;
            pix_b_ff    <= `RIP_INT_NONE;
         end
         if ((st_ff == RIP_PAL) && src_ack) begin
            case (pal_ix_ff)
               2'h0: pix_r_ff <= src_data;
               2'h1: pix_g_ff <= src_data;
               default: pix_b_ff <= src_data;
            endcase
         end
      end
   end
   assign pix_index = pix_idx_ff;
   assign pix_set   = !colour_ff && pix_idx_ff[0];
   assign pix_red   = pix_r_ff;
   assign pix_green = pix_g_ff;
   assign pix_blue  = pix_b_ff;
   assign pix_last  = pix_last_ff;
   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_ff    <= 1'b0;
         img_off_ff <= 16'h0000;
         irq_en_ff  <= 2'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `RIP_REG_CTRL: mode_ff <= reg_wdata[`RIP_CTRL_COLOUR];
            `RIP_REG_IMG_OFF: img_off_ff <= reg_wdata[15:0];
            `RIP_REG_IRQ_EN: irq_en_ff <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end
   // Unmapped and write-only offsets read back as zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `RIP_REG_CTRL: rdata_ff <= {30'h0, mode_ff, 1'b0};
            `RIP_REG_IMG_OFF: rdata_ff <= {16'h0000, img_off_ff};
            `RIP_REG_STATUS: rdata_ff <= {29'h0, err_ff, done_ff,
                                          (st_ff != RIP_IDLE)};
            `RIP_REG_GEOM: rdata_ff <= {ents_ff[7:0], bpp_ff, height_ff,
                                        width_ff};
            `RIP_REG_IRQ_STAT: rdata_ff <= {30'h0, irq_stat_ff};
            `RIP_REG_IRQ_EN: rdata_ff <= {30'h0, irq_en_ff};
            `RIP_REG_POINTS: rdata_ff <= {16'h0000, pts_ff};
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_ff;
   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // A new event in the clearing cycle survives, set beats clear.
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_stat_ff <= 2'h0;
      end else begin
         if (reg_wr && (reg_addr == `RIP_REG_IRQ_CLR)) begin
            irq_stat_ff <= irq_stat_ff & ~reg_wdata[1:0];
         end
         if (ev_done) begin
            irq_stat_ff[`RIP_IRQ_DONE] <= 1'b1;
         end
         if (ev_err) begin
            irq_stat_ff[`RIP_IRQ_ERR] <= 1'b1;
         end
      end
   end
   assign irq = |(irq_stat_ff & irq_en_ff);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   mono_black_a: assert property (@(posedge clock) disable iff (rst)
      pix_valid && !colour_ff |-> pix_red == 8'h00 && pix_green == 8'h00 && pix_blue == 8'h00)
      else $error("mono point carries colour");
   mono_set_a: assert property (@(posedge clock) disable iff (rst)
      pix_valid && !colour_ff |-> pix_set == pix_index[0] && pix_index[7:1] == 7'h00)
      else $error("mono set bit wrong");
   bad_depth_a: assert property (@(posedge clock) disable iff (rst)
      st_ff == RIP_CHECK && colour_ff && bpp_ff > 8'h08 |=> err_ff ##1 done_ff)
      else $error("bad depth not flagged");
   zero_count_a: assert property (@(posedge clock) disable iff (rst)
      st_ff == RIP_HDR && src_ack && hdr_ix_ff == 3'h3 && src_data == 8'h00
      |=> ents_ff == 9'h100)
      else $error("zero entry count not 256");
   pal_addr_a: assert property (@(posedge clock) disable iff (rst)
      $rose(st_ff == RIP_PAL) |->
      src_addr == pal_off_ff + {8'h00, idx_ff} * 16'h0003)
      else $error("palette address wrong");
   over_index_a: assert property (@(posedge clock) disable iff (rst)
      st_ff == RIP_BIT && left_ff != 4'h0 && last_bit && colour_ff &&
      {1'b0, nxt_idx} >= ents_ff |=> err_ff && st_ff == RIP_DONE)
      else $error("index overflow not flagged");
   done_count_a: assert property (@(posedge clock) disable iff (rst)
      $rose(done_ff) && !err_ff |-> pts_ff == total)
      else $error("done before all points");
   pix_hold_a: assert property (@(posedge clock) disable iff (rst)
      pix_valid && !pix_ready |=> pix_valid && $stable(pix_index))
      else $error("point dropped while stalled");
   fetch_hold_a: assert property (@(posedge clock) disable iff (rst)
      src_req && !src_ack |=> src_req && $stable(src_addr))
      else $error("fetch request withdrawn");
endmodule : rip_decoder
`default_nettype wire

/* File: rtl/rip_pkg.sv */
// ------------------------------------------------------------------
// Types shared by the decoder
// ------------------------------------------------------------------
package rip_pkg;
   typedef enum logic [2:0] {
      RIP_IDLE, RIP_HDR, RIP_CHECK, RIP_BIT, RIP_BODY, RIP_PAL,
      RIP_EMIT, RIP_DONE
   } rip_state_t;
endpackage : rip_pkg
